//--- pkg/crme_pkg.sv
package crme_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int UPDATE_DIV = 12;
    localparam int TICK_NS = UPDATE_DIV * CLK_PERIOD_NS;
    localparam int CUR_TAU_OFF_MS = 80;
    localparam int CUR_FULL_OFF_MS = 960;
    localparam int CUR_TAU_ON_MS = 40;
    localparam int CUR_FULL_ON_MS = 1680;
    localparam int VOLT_TAU_MS = 100;
    localparam int VOLT_BW_HZ = 260;
    localparam int CUR_BW_HZ = 14000;
    // smoother time constants in update ticks, shift is floor(log2)
    localparam longint CUR_TAU_OFF_TICKS = longint'(CUR_TAU_OFF_MS) * 1000000 / TICK_NS;
    localparam longint CUR_TAU_ON_TICKS = longint'(CUR_TAU_ON_MS) * 1000000 / TICK_NS;
    localparam longint VOLT_TAU_TICKS = longint'(VOLT_TAU_MS) * 1000000 / TICK_NS;
    localparam int CUR_SHIFT_OFF_DEF = $clog2(CUR_TAU_OFF_TICKS + 1) - 1;
    localparam int CUR_SHIFT_ON_DEF = $clog2(CUR_TAU_ON_TICKS + 1) - 1;
    localparam int VOLT_SHIFT_DEF = $clog2(VOLT_TAU_TICKS + 1) - 1;
    // band-limit pole: ticks per radian at the corner frequency
    localparam longint VOLT_BW_TICKS = 64'd1000000000000 / (longint'(TICK_NS) * 6283 * VOLT_BW_HZ);
    localparam int VOLT_BW_SHIFT = $clog2(VOLT_BW_TICKS + 1) - 1;
    // widths
    localparam int NPHASE = 3;
    localparam int NLANE = 2 * NPHASE;
    localparam int SMP_W = 24;
    localparam int MAG_W = 24;
    localparam int REM_W = MAG_W + 2;
    localparam int RAD_W = 2 * MAG_W;
    localparam int FRAC_W = 20;
    localparam int ACC_W = RAD_W + FRAC_W;
    localparam int VF_FRAC = 12;
    localparam int TRIM_W = 12;
    localparam int TRIM_SH = 14;
    localparam int ADR_W = 8;
    // register byte offsets
    localparam logic [ADR_W-1:0] OFS_MAG_A = 8'h00;
    localparam logic [ADR_W-1:0] OFS_MAG_B = 8'h04;
    localparam logic [ADR_W-1:0] OFS_MAG_C = 8'h08;
    localparam logic [ADR_W-1:0] OFS_TRIM_A = 8'h0c;
    localparam logic [ADR_W-1:0] OFS_TRIM_B = 8'h10;
    localparam logic [ADR_W-1:0] OFS_TRIM_C = 8'h14;
    localparam logic [ADR_W-1:0] OFS_CTRL = 8'h18;
    localparam logic [ADR_W-1:0] OFS_VMAG_A = 8'h1c;
    localparam logic [ADR_W-1:0] OFS_VMAG_B = 8'h20;
    localparam logic [ADR_W-1:0] OFS_VMAG_C = 8'h24;
    localparam logic [ADR_W-1:0] OFS_FRESH = 8'h28;
    // fields and reset values
    localparam int CTRL_INTEG_BIT = 0;
    localparam logic CTRL_INTEG_RST = 1'b0;
    localparam logic [TRIM_W-1:0] TRIM_RST = 12'h000;
    localparam logic [MAG_W-1:0] MAG_RST = 24'h000000;
endpackage

//--- rtl/crme_top.sv
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
module crme_top
#(
    parameter int CUR_SHIFT_OFF = crme_pkg::CUR_SHIFT_OFF_DEF,
    parameter int CUR_SHIFT_ON = crme_pkg::CUR_SHIFT_ON_DEF,
    parameter int VOLT_SHIFT = crme_pkg::VOLT_SHIFT_DEF
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // sample stream
    input wire logic sample_valid_i,
    input wire logic [crme_pkg::SMP_W-1:0] cur_sample_a_i,
    input wire logic [crme_pkg::SMP_W-1:0] cur_sample_b_i,
    input wire logic [crme_pkg::SMP_W-1:0] cur_sample_c_i,
    input wire logic [crme_pkg::SMP_W-1:0] volt_sample_a_i,
    input wire logic [crme_pkg::SMP_W-1:0] volt_sample_b_i,
    input wire logic [crme_pkg::SMP_W-1:0] volt_sample_c_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [crme_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // status
    output logic integ_en_o
);
    import crme_pkg::*;

    if (CUR_SHIFT_OFF < 1 || CUR_SHIFT_OFF > FRAC_W || CUR_SHIFT_ON < 1 || CUR_SHIFT_ON > FRAC_W
        || VOLT_SHIFT < 1 || VOLT_SHIFT > FRAC_W)
    begin : g_bad_shift
        $error("smoother shift out of range");
    end

    ////////////////////////////////////////////////////////////////
    // one step of the digit-by-digit square root

    function automatic logic [REM_W+MAG_W-1:0] sq_step(
        input logic [REM_W-1:0] rem,
        input logic [MAG_W-1:0] root,
        input logic [1:0] pair
    );
        logic [REM_W+1:0] r;
        logic [REM_W+1:0] t;
        r = {rem, pair};
        t = {2'b00, root, 2'b01};
        if (r >= t)
        begin
            sq_step = {REM_W'(r - t), root[MAG_W-2:0], 1'b1};
        end
        else
        begin
            sq_step = {r[REM_W-1:0], root[MAG_W-2:0], 1'b0};
        end
    endfunction

    function automatic logic [TRIM_W-1:0] merge_trim(
        input logic [TRIM_W-1:0] old,
        input logic [31:0] dat,
        input logic [3:0] sel
    );
        merge_trim = old;
        if (sel[0])
        begin
            merge_trim[7:0] = dat[7:0];
        end
        if (sel[1])
        begin
            merge_trim[TRIM_W-1:8] = dat[TRIM_W-1:8];
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // update sequencer: twelve clocks per result

    logic [3:0] phase;
    logic tick;
    localparam logic [3:0] PH_LAST = 4'(UPDATE_DIV - 1);

    assign tick = (phase == PH_LAST);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase <= 4'h0;
        end
        else if (tick)
        begin
            phase <= 4'h0;
        end
        else
        begin
            phase <= phase + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // sample capture and register state

    logic [SMP_W-1:0] smp [NLANE];
    logic [TRIM_W-1:0] trim [NLANE];
    logic [MAG_W-1:0] mag [NLANE];
    logic [NLANE-1:0] fresh;
    logic [NLANE-1:0] upd;
    logic ctrl_integ;
    logic req;
    logic wr;
    logic [31:0] rd_val;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < NLANE; i++)
            begin
                smp[i] <= '0;
            end
        end
        else if (sample_valid_i)
        begin
            smp[0] <= cur_sample_a_i;
            smp[1] <= cur_sample_b_i;
            smp[2] <= cur_sample_c_i;
            smp[3] <= volt_sample_a_i;
            smp[4] <= volt_sample_b_i;
            smp[5] <= volt_sample_c_i;
        end
    end

    ////////////////////////////////////////////////////////////////
    // rms lanes, all six in parallel

    for (genvar g = 0; g < NLANE; g++)
    begin : g_lane
        logic signed [SMP_W-1:0] src;
        logic [SMP_W-1:0] absv;
        logic [RAD_W-1:0] sq;
        logic [ACC_W-1:0] acc;
        logic signed [ACC_W:0] diff;
        logic [4:0] sh;
        logic signed [RAD_W:0] rad_full;
        logic [RAD_W-1:0] rad_clamp;
        logic [RAD_W-1:0] rad_in;
        logic [RAD_W-1:0] rad_sh;
        logic [REM_W-1:0] rem;
        logic [MAG_W-1:0] root;
        logic [REM_W+MAG_W-1:0] s1;
        logic [REM_W+MAG_W-1:0] s2;

        if (g >= NPHASE)
        begin : g_bl
            // first-order pole keeps voltage content above the corner out
            logic signed [SMP_W+VF_FRAC-1:0] vf;
            logic signed [SMP_W+VF_FRAC:0] vdiff;
            assign vdiff = $signed({smp[g][SMP_W-1], smp[g], {VF_FRAC{1'b0}}}) - $signed({vf[SMP_W+VF_FRAC-1], vf});
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    vf <= '0;
                end
                else if (tick)
                begin
                    vf <= vf + (SMP_W+VF_FRAC)'(vdiff >>> VOLT_BW_SHIFT);
                end
            end
            assign src = vf[SMP_W+VF_FRAC-1:VF_FRAC];
            assign sh = 5'(VOLT_SHIFT);
        end
        else
        begin : g_nb
            // current path takes samples unfiltered; update rate far above 14 kHz
            assign src = smp[g];
            assign sh = ctrl_integ ? 5'(CUR_SHIFT_ON) : 5'(CUR_SHIFT_OFF);
        end

        // squaring in sample units keeps the result lsb equal to a sample lsb
        assign absv = src[SMP_W-1] ? SMP_W'(-src) : SMP_W'(src);
        assign sq = absv * absv;
        assign diff = $signed({1'b0, sq, {FRAC_W{1'b0}}}) - $signed({1'b0, acc});

        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                acc <= '0;
            end
            else if (tick)
            begin
                acc <= acc + ACC_W'(diff >>> sh);
            end
        end

        // offset term is trim times 16384, added to the squared value
        assign rad_full = $signed({1'b0, acc[ACC_W-1:FRAC_W]})
                        + $signed({{(RAD_W+1-TRIM_W-TRIM_SH){trim[g][TRIM_W-1]}}, trim[g], {TRIM_SH{1'b0}}});
        assign rad_clamp = rad_full[RAD_W] ? '0 : rad_full[RAD_W-1:0];
        assign rad_in = (phase == 4'h0) ? rad_clamp : rad_sh;
        assign s1 = sq_step((phase == 4'h0) ? '0 : rem, (phase == 4'h0) ? '0 : root, rad_in[RAD_W-1:RAD_W-2]);
        assign s2 = sq_step(s1[REM_W+MAG_W-1:MAG_W], s1[MAG_W-1:0], rad_in[RAD_W-3:RAD_W-4]);
        assign upd[g] = tick;

        // two root bits per clock: 24 bits in exactly 12 clocks
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                rad_sh <= '0;
                rem <= '0;
                root <= '0;
            end
            else
            begin
                rad_sh <= {rad_in[RAD_W-5:0], 4'h0};
                rem <= s2[REM_W+MAG_W-1:MAG_W];
                root <= s2[MAG_W-1:0];
            end
        end

        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                mag[g] <= MAG_RST;
            end
            else if (tick)
            begin
                mag[g] <= s2[MAG_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // wishbone slave

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= req;
        end
    end

    always_comb
    begin
        rd_val = 32'h00000000;
        if (wb_adr_i == OFS_MAG_A)
        begin
            rd_val[MAG_W-1:0] = mag[0];
        end
        else if (wb_adr_i == OFS_MAG_B)
        begin
            rd_val[MAG_W-1:0] = mag[1];
        end
        else if (wb_adr_i == OFS_MAG_C)
        begin
            rd_val[MAG_W-1:0] = mag[2];
        end
        else if (wb_adr_i == OFS_TRIM_A)
        begin
            rd_val[TRIM_W-1:0] = trim[0];
        end
        else if (wb_adr_i == OFS_TRIM_B)
        begin
            rd_val[TRIM_W-1:0] = trim[1];
        end
        else if (wb_adr_i == OFS_TRIM_C)
        begin
            rd_val[TRIM_W-1:0] = trim[2];
        end
        else if (wb_adr_i == OFS_CTRL)
        begin
            rd_val[CTRL_INTEG_BIT] = ctrl_integ;
        end
        else if (wb_adr_i == OFS_VMAG_A)
        begin
            rd_val[MAG_W-1:0] = mag[3];
        end
        else if (wb_adr_i == OFS_VMAG_B)
        begin
            rd_val[MAG_W-1:0] = mag[4];
        end
        else if (wb_adr_i == OFS_VMAG_C)
        begin
            rd_val[MAG_W-1:0] = mag[5];
        end
        else if (wb_adr_i == OFS_FRESH)
        begin
            rd_val[NLANE-1:0] = fresh;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_dat_o <= 32'h00000000;
        end
        else if (req)
        begin
            wb_dat_o <= rd_val;
        end
    end

    // trims and control; voltage lanes carry no trim
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < NLANE; i++)
            begin
                trim[i] <= TRIM_RST;
            end
            ctrl_integ <= CTRL_INTEG_RST;
        end
        else if (wr)
        begin
            if (wb_adr_i == OFS_TRIM_A)
            begin
                trim[0] <= merge_trim(trim[0], wb_dat_i, wb_sel_i);
            end
            else if (wb_adr_i == OFS_TRIM_B)
            begin
                trim[1] <= merge_trim(trim[1], wb_dat_i, wb_sel_i);
            end
            else if (wb_adr_i == OFS_TRIM_C)
            begin
                trim[2] <= merge_trim(trim[2], wb_dat_i, wb_sel_i);
            end
            else if (wb_adr_i == OFS_CTRL && wb_sel_i[0])
            begin
                ctrl_integ <= wb_dat_i[CTRL_INTEG_BIT];
            end
        end
    end

    assign integ_en_o = ctrl_integ;

    // fresh bit per lane: set on refresh, cleared by reading that magnitude; set wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fresh <= '0;
        end
        else
        begin
            for (int i = 0; i < NLANE; i++)
            begin
                if (upd[i])
                begin
                    fresh[i] <= 1'b1;
                end
                else if (req && !wb_we_i && wb_adr_i == ((i < NPHASE) ? OFS_MAG_A : OFS_VMAG_A)
                         + ADR_W'(4 * (i % NPHASE)))
                begin
                    fresh[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks

    logic [RAD_W-1:0] snap0;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            snap0 <= '0;
        end
        else if (phase == 4'h0)
        begin
            snap0 <= g_lane[0].rad_clamp;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    tick_period_a: assert property (tick |-> ##12 tick)
        else $error("update tick not every 12 clocks");
    tick_gap_a: assert property (tick |=> !tick [*8])
        else $error("update tick too early");
    mag_timing_a: assert property ($changed(mag[0]) |-> $past(phase) == PH_LAST)
        else $error("magnitude changed off tick");
    sqrt_exact_a: assert property ($past(phase) == PH_LAST && !$past(rst_i, 1)
        |-> (RAD_W+2)'(mag[0]) * (RAD_W+2)'(mag[0]) <= (RAD_W+2)'(snap0)
            && ((RAD_W+2)'(mag[0]) + 1) * ((RAD_W+2)'(mag[0]) + 1) > (RAD_W+2)'(snap0))
        else $error("root does not match radicand");
    clamp_zero_a: assert property (phase == 4'h0 && g_lane[0].rad_full[RAD_W] |=> snap0 == '0)
        else $error("negative radicand not clamped");
    trim_write_a: assert property (wr && wb_adr_i == OFS_TRIM_A && wb_sel_i[1:0] == 2'b11
        |=> trim[0] == $past(wb_dat_i[TRIM_W-1:0]))
        else $error("trim write lost");
    smooth_bound_a: assert property (tick && g_lane[0].diff > 0
        |=> g_lane[0].acc >= $past(g_lane[0].acc)
            && g_lane[0].acc <= {$past(g_lane[0].sq), {FRAC_W{1'b0}}})
        else $error("smoother overshoots or reverses");
    sample_take_a: assert property (sample_valid_i |=> smp[0] == $past(cur_sample_a_i))
        else $error("current sample not captured");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule

//--- tb/crme_src.sv
`timescale 1ns/10ps
module crme_src
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // stimulus control
    input wire logic alt_i,
    input wire logic slow_i,
    input wire logic [23:0] lvl_a_i,
    input wire logic [23:0] lvl_b_i,
    input wire logic [23:0] lvl_c_i,
    input wire logic [23:0] vlvl_i,
    // sample stream
    output logic vld_o,
    output logic [23:0] cur_a_o,
    output logic [23:0] cur_b_o,
    output logic [23:0] cur_c_o,
    output logic [23:0] volt_o
);
    logic [3:0] cnt;
    logic [1:0] gap;
    logic neg;
    ////////////////////////////////////////////////////////////
    // sign flips once per 12-clock window in alternating mode
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt <= 4'h0;
            gap <= 2'h0;
            neg <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == 4'hb) ? 4'h0 : cnt + 4'h1;
            gap <= gap + 2'h1;
            if (cnt == 4'hb && alt_i)
                neg <= ~neg;
        end
    end
    ////////////////////////////////////////////////////////////
    // idle cycles carry inverted data so stale values never pass
    assign vld_o = !slow_i || gap == 2'h0;
    assign cur_a_o = vld_o ? (neg ? -lvl_a_i : lvl_a_i) : ~lvl_a_i;
    assign cur_b_o = vld_o ? (neg ? -lvl_b_i : lvl_b_i) : ~lvl_b_i;
    assign cur_c_o = vld_o ? (neg ? -lvl_c_i : lvl_c_i) : ~lvl_c_i;
    assign volt_o = vld_o ? (neg ? -vlvl_i : vlvl_i) : ~vlvl_i;
endmodule

//--- tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    import crme_pkg::*;
    logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, integ_en, alt, slow, vld;
    logic [ADR_W-1:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_rdat, rd;
    logic [23:0] lvl[3];
    logic [23:0] vlvl, ca, cb, cc, vs;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int n_mismatch, checks_done, seed, v, x, np[2];
    ////////////////////////////////////////////////////////////
    crme_top #(.CUR_SHIFT_OFF(3), .CUR_SHIFT_ON(2), .VOLT_SHIFT(3)) crme_top_i (.clk_i(clk_i), .rst_i(rst_i),
        .sample_valid_i(vld), .cur_sample_a_i(ca), .cur_sample_b_i(cb), .cur_sample_c_i(cc),
        .volt_sample_a_i(vs), .volt_sample_b_i(vs), .volt_sample_c_i(vs), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .integ_en_o(integ_en));
    crme_src crme_src_i (.clk_i(clk_i), .rst_i(rst_i), .alt_i(alt), .slow_i(slow), .lvl_a_i(lvl[0]),
        .lvl_b_i(lvl[1]), .lvl_c_i(lvl[2]), .vlvl_i(vlvl), .vld_o(vld), .cur_a_o(ca), .cur_b_o(cb),
        .cur_c_o(cc), .volt_o(vs));
    ////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // classic single cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= sel;
        wb_wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 100);
        if (n >= 100)
        begin
            n_mismatch++;
            stop_test();
        end
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdx(input logic [7:0] adr, input logic en, input logic [31:0] exp);
        exp_q.push_back({en, exp});
        wb(1'b0, adr, 4'hf, 32'h0);
    endtask
    function automatic logic near(input logic [31:0] q, input int t);
        return q <= t && q + 1 >= t;
    endfunction
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////
    // scoreboard: oldest note against each read answer
    always @(posedge clk_i)
        if (wb_ack === 1'b1 && wb_cyc === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            if (e[32])
                check(wb_rdat, e[31:0]);
        end
    initial
    begin
        #900000;
        n_mismatch++;
        stop_test();
    end
    ////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'hd0b01e72;
        {rst_i, wb_cyc, wb_stb, wb_we, alt, slow} = 6'h20;
        {wb_adr, wb_sel, wb_wdat, vlvl} = '0;
        lvl = '{24'h0, 24'h0, 24'h0};
        wt(5);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a <= 'h24; a += 4)
            rdx(a[7:0], 1'b1, 32'h0);
        rdx(8'h40, 1'b1, 32'h0);
        wb(1'b1, OFS_TRIM_A, 4'h1, 32'hffff_ffff);
        rdx(OFS_TRIM_A, 1'b1, 32'h0ff);
        wb(1'b1, OFS_TRIM_A, 4'h2, 32'hffff_ffff);
        rdx(OFS_TRIM_A, 1'b1, 32'hfff);
        wb(1'b1, OFS_MAG_A, 4'hf, 32'h123);
        wb(1'b1, 8'h40, 4'hf, 32'h55);
        wt(24);
        rdx(OFS_MAG_A, 1'b1, 32'h0);
        rdx(8'h40, 1'b1, 32'h0);
        $display("test registers done");
        wb(1'b1, OFS_TRIM_A, 4'hf, 32'h4);
        wb(1'b1, OFS_TRIM_B, 4'hf, 32'h1);
        wt(48);
        rdx(OFS_FRESH, 1'b1, 32'h3f);
        rdx(OFS_MAG_A, 1'b1, 32'd256);
        rdx(OFS_MAG_B, 1'b1, 32'd128);
        wb(1'b1, OFS_TRIM_A, 4'hf, 32'd61);
        wb(1'b1, OFS_TRIM_B, 4'hf, 32'hfe2);
        wb(1'b1, OFS_TRIM_C, 4'hf, 32'hf9c);
        lvl <= '{24'd1000, 24'd1000, 24'd1000};
        wt(4000);
        rdx(OFS_MAG_A, 1'b1, 32'd1414);
        rdx(OFS_MAG_B, 1'b1, 32'd713);
        rdx(OFS_MAG_C, 1'b1, 32'd0);
        for (int p = 0; p < 3; p++)
            wb(1'b1, OFS_TRIM_A + 8'(4 * p), 4'hf, 32'h0);
        $display("test trim done");
        for (int i = 0; i < 3; i++)
        begin
            slow <= i[0];
            for (int p = 0; p < 3; p++)
            begin
                v = $random(seed) % 1048576;
                lvl[p] <= v[23:0];
            end
            wt(4000);
            for (int p = 0; p < 3; p++)
            begin
                x = lvl[p][23] ? -int'(signed'(lvl[p])) : int'(lvl[p]);
                rdx(OFS_MAG_A + 8'(4 * p), 1'b0, 32'h0);
                check({31'h0, near(rd, x)}, 32'h1);
            end
        end
        slow <= 1'b0;
        $display("test random done");
        alt <= 1'b1;
        lvl <= '{24'd4000, 24'd4000, 24'd4000};
        vlvl <= 24'd4000;
        wt(4000);
        rdx(OFS_MAG_A, 1'b0, 32'h0);
        check({31'h0, near(rd, 4000)}, 32'h1);
        rdx(OFS_VMAG_A, 1'b0, 32'h0);
        check({31'h0, rd < 2000}, 32'h1);
        alt <= 1'b0;
        // band-limit pole is slow: dc needs many thousand ticks to pass half
        wt(45000);
        rdx(OFS_VMAG_A, 1'b0, 32'h0);
        check({31'h0, rd > 2000}, 32'h1);
        $display("test bandwidth done");
        for (int g = 0; g < 2; g++)
        begin
            wb(1'b1, OFS_CTRL, 4'h1, 32'(g));
            check({31'h0, integ_en}, 32'(g));
            lvl <= '{24'h0, 24'h0, 24'h0};
            wt(4000);
            lvl <= '{24'd8000, 24'd8000, 24'd8000};
            np[g] = 0;
            do
            begin
                rdx(OFS_MAG_A, 1'b0, 32'h0);
                np[g]++;
            end
            while (rd < 5040 && np[g] < 300);
        end
        check({31'h0, np[1] < np[0] && np[0] < 300}, 32'h1);
        $display("test settling done");
        stop_test();
    end
endmodule
